// >>> pma_pkg.sv
// Purpose: shared constants for the power-monitor converter sequencer
// Assumes: 40 MHz system clock, 1 MHz conversion time base
// Notes:   byte offsets on a 6-bit avalon byte address
package pma_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned OSC_HZ        = 1_000_000;
    localparam int unsigned TICK_DIV_DEF  = CLK_HZ / OSC_HZ;
    localparam int unsigned DELAY_STEP_US = 2000;
    localparam int unsigned ADDR_W        = 6;

    // register byte offsets
    localparam logic [5:0] OFF_CONFIG = 6'h00;
    localparam logic [5:0] OFF_ADC    = 6'h04;
    localparam logic [5:0] OFF_SHUNT  = 6'h08;
    localparam logic [5:0] OFF_BUS    = 6'h0c;
    localparam logic [5:0] OFF_TEMP   = 6'h10;
    localparam logic [5:0] OFF_POWER  = 6'h14;
    localparam logic [5:0] OFF_DIAG   = 6'h18;
    localparam logic [5:0] OFF_THR0   = 6'h1c;

    // field positions
    localparam int unsigned CFG_RST_BIT  = 0;
    localparam int unsigned CFG_DLY_LSB  = 8;
    localparam int unsigned ADC_MODE_LSB = 12;
    localparam int unsigned ADC_CTB_LSB  = 9;
    localparam int unsigned ADC_CTS_LSB  = 6;
    localparam int unsigned ADC_CTT_LSB  = 3;
    localparam int unsigned ADC_AVG_LSB  = 0;
    localparam int unsigned DG_OPT_LSB   = 12;

    // reset values
    localparam logic [7:0]  DLY_RST = 8'h00;
    localparam logic [15:0] ADC_RST = 16'hf000;
    localparam logic [3:0]  OPT_RST = 4'h0;
    localparam logic [15:0] THR_RST [6] = '{16'h8000, 16'h7fff, 16'h7fff,
                                            16'h0000, 16'h7fff, 16'h7fff};

    // channel codes
    localparam logic [1:0] CH_SHUNT = 2'h0;
    localparam logic [1:0] CH_BUS   = 2'h1;
    localparam logic [1:0] CH_TEMP  = 2'h2;
    localparam logic [1:0] CH_NONE  = 2'h3;

    typedef enum logic [1:0] {
        PMA_IDLE = 2'b00,
        PMA_WAIT = 2'b01,
        PMA_CONV = 2'b11
    } pma_state_t;

    // conversion time in oscillator ticks (microseconds)
    function automatic logic [12:0] ct_us(input logic [2:0] code);
        unique case (code)
            3'h0: return 13'd50;
            3'h1: return 13'd84;
            3'h2: return 13'd150;
            3'h3: return 13'd280;
            3'h4: return 13'd540;
            3'h5: return 13'd1052;
            3'h6: return 13'd2074;
            3'h7: return 13'd4120;
        endcase
    endfunction : ct_us

    // averaging code to log2 of sample count (1 .. 1024)
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        unique case (code)
            3'h0: return 4'd0;
            3'h1: return 4'd2;
            3'h2: return 4'd4;
            3'h3: return 4'd6;
            3'h4: return 4'd7;
            3'h5: return 4'd8;
            3'h6: return 4'd9;
            3'h7: return 4'd10;
        endcase
    endfunction : avg_shift

    function automatic logic [5:0] thr_off(input int unsigned i);
        return 6'(OFF_THR0 + 6'(4 * i));
    endfunction : thr_off
endpackage : pma_pkg

// >>> pma_tick_div.sv
// Purpose: oscillator time base, one-cycle tick every DIV clocks
// Assumes: single clock domain
// Notes:   restart realigns the phase so conversion lengths are exact
`timescale 1ns/100ps
module pma_tick_div #(
    parameter int unsigned DIV = 40
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned CW = $clog2(DIV);

    // two idle cycles between ticks are assumed by the period check
    if (DIV < 3) begin : g_bad_div
        $error("pma_tick_div: DIV must be at least 3");
    end

    logic [CW-1:0] cnt_r;

    assign tick = cnt_r == CW'(DIV - 1);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (restart || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    chk_tick_period: assert property (@(posedge clk) disable iff (!resetn)
        tick && !restart |=> !tick [*2])
        else $error("time base tick repeated too early");
endmodule : pma_tick_div

// >>> pma_sequencer.sv
// Purpose: converter sequencing, results, limit checks and alert pin
// Assumes: avalon-mm slave with one wait state; analog front end outside
// Notes:   current/power arithmetic arrives on calc_power, computed outside
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module pma_sequencer #(
    parameter int unsigned TICK_DIV = pma_pkg::TICK_DIV_DEF
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // avalon-mm register slave
    input  wire logic [pma_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    // converter front end
    output logic                            adc_start,
    output logic      [1:0]                 adc_chan,
    input  wire logic [15:0]                adc_sample,
    // background arithmetic and health
    input  wire logic [15:0]                calc_power,
    input  wire logic                       calc_overflow,
    input  wire logic                       trim_ok,
    // open-drain alert pin
    output logic                            alert_out,
    output logic                            alert_oe
);
    import pma_pkg::*;

    if (TICK_DIV < 3) begin : g_bad_tick
        $error("pma_sequencer: TICK_DIV must be at least 3");
    end

    logic              ack_r, req, wr_go, rd_go, diag_rd, adc_wr, cfg_wr, soft_rst, shut_sel;
    logic [7:0]        dly_r;
    logic [15:0]       adc_cfg_r;
    logic [3:0]        opt_r;
    logic [15:0]       thr_r [6];
    logic [15:0]       res_r [4];
    logic signed [26:0] acc_r [3];
    logic signed [26:0] sum_v [3];
    logic [15:0]       avg_v [3];
    logic [15:0]       cv [3];
    logic [2:0]        cen, en;
    logic [3:0]        mode, shift;
    logic [5:0]        hit, upd, cond_r, flags_r;
    logic              done_r, ovf_r, hold_r, live, act, tick;
    logic              conv_end, pass_end, seq_end;
    logic [1:0]        chan_r, first_ch, nxt_ch;
    logic [18:0]       dly_cnt_r;
    logic [12:0]       ct_cnt_r;
    logic [10:0]       samp_r, navg_m1;
    logic [15:0]       diag_w;
    logic [31:0]       rd_mux, conv_cyc_r;
    pma_state_t        state_r;

    // one wait state: data is ready and side effects fire on the second edge
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign rd_go           = avs_read & ack_r;
    assign diag_rd         = rd_go && avs_address == OFF_DIAG;
    assign adc_wr          = wr_go && avs_address == OFF_ADC;
    assign cfg_wr          = wr_go && avs_address == OFF_CONFIG;
    assign soft_rst        = cfg_wr & avs_writedata[CFG_RST_BIT];
    assign shut_sel        = avs_writedata[ADC_MODE_LSB +: 3] == 3'b000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // mode bits: 0 bus, 1 shunt, 2 temperature, 3 continuous
    assign mode    = adc_cfg_r[ADC_MODE_LSB +: 4];
    assign en      = {mode[2], mode[0], mode[1]};
    assign shift   = avg_shift(adc_cfg_r[ADC_AVG_LSB +: 3]);
    assign navg_m1 = 11'((12'd1 << shift) - 12'd1);

    function automatic logic [1:0] chan_after(input logic [2:0] ena, input logic [2:0] from);
        logic [1:0] r;
        r = CH_NONE;
        for (int c = 2; c >= 0; c--) begin
            if (3'(c) >= from && ena[c]) begin
                r = 2'(c);
            end
        end
        return r;
    endfunction : chan_after

    function automatic logic [12:0] ct_len(input logic [1:0] ch, input logic [15:0] cfg);
        unique case (ch)
            CH_SHUNT: return ct_us(cfg[ADC_CTS_LSB +: 3]);
            CH_BUS:   return ct_us(cfg[ADC_CTB_LSB +: 3]);
            default:  return ct_us(cfg[ADC_CTT_LSB +: 3]);
        endcase
    endfunction : ct_len

    // configuration and limit registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dly_r     <= DLY_RST;
            adc_cfg_r <= ADC_RST;
            opt_r     <= OPT_RST;
            for (int i = 0; i < 6; i++) begin
                thr_r[i] <= THR_RST[i];
            end
        end else if (soft_rst) begin
            dly_r     <= DLY_RST;
            adc_cfg_r <= ADC_RST;
            opt_r     <= OPT_RST;
            for (int i = 0; i < 6; i++) begin
                thr_r[i] <= THR_RST[i];
            end
        end else begin
            if (cfg_wr) begin
                dly_r <= avs_writedata[CFG_DLY_LSB +: 8];
            end
            if (adc_wr) begin
                adc_cfg_r <= avs_writedata[15:0];
            end
            if (wr_go && avs_address == OFF_DIAG) begin
                opt_r <= avs_writedata[DG_OPT_LSB +: 4];
            end
            for (int i = 0; i < 6; i++) begin
                if (wr_go && avs_address == thr_off(i)) begin
                    thr_r[i] <= avs_writedata[15:0];
                end
            end
        end
    end

    pma_tick_div #(.DIV(TICK_DIV)) u_tick (
        .clk     (clk),
        .resetn  (resetn),
        .restart (soft_rst | adc_wr),
        .tick    (tick)
    );

    assign first_ch = chan_after(en, 3'd0);
    assign nxt_ch   = chan_after(en, 3'(chan_r) + 3'd1);
    assign conv_end = state_r == PMA_CONV && tick && ct_cnt_r == 13'd1;
    assign pass_end = conv_end && nxt_ch == CH_NONE;
    assign seq_end  = pass_end && samp_r == navg_m1;
    assign adc_chan = chan_r;

    // sequencer; starts after reset since the reset mode is continuous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= PMA_WAIT;
            dly_cnt_r <= '0;
            ct_cnt_r  <= '0;
            chan_r    <= CH_SHUNT;
            samp_r    <= '0;
            adc_start <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (soft_rst) begin
                state_r   <= PMA_WAIT;
                dly_cnt_r <= '0;
                samp_r    <= '0;
            end else if (adc_wr) begin
                state_r   <= shut_sel ? PMA_IDLE : PMA_WAIT;
                dly_cnt_r <= 19'(dly_r * DELAY_STEP_US);
                samp_r    <= '0;
            end else begin
                unique case (state_r)
                    PMA_IDLE: begin
                        state_r <= PMA_IDLE;
                    end
                    PMA_WAIT: begin
                        if (tick && dly_cnt_r != '0) begin
                            dly_cnt_r <= dly_cnt_r - 1'b1;
                        end else if (tick && first_ch == CH_NONE) begin
                            state_r <= PMA_IDLE;
                        end else if (tick) begin
                            state_r   <= PMA_CONV;
                            chan_r    <= first_ch;
                            ct_cnt_r  <= ct_len(first_ch, adc_cfg_r);
                            adc_start <= 1'b1;
                        end
                    end
                    PMA_CONV: begin
                        if (conv_end && nxt_ch != CH_NONE) begin
                            chan_r    <= nxt_ch;
                            ct_cnt_r  <= ct_len(nxt_ch, adc_cfg_r);
                            adc_start <= 1'b1;
                        end else if (seq_end && !mode[3]) begin
                            state_r <= PMA_IDLE;
                            samp_r  <= '0;
                        end else if (conv_end) begin
                            samp_r    <= seq_end ? 11'd0 : samp_r + 11'd1;
                            chan_r    <= first_ch;
                            ct_cnt_r  <= ct_len(first_ch, adc_cfg_r);
                            adc_start <= 1'b1;
                        end else if (tick) begin
                            ct_cnt_r <= ct_cnt_r - 1'b1;
                        end
                    end
                    default: begin
                        state_r <= PMA_IDLE;
                    end
                endcase
            end
        end
    end

    // sample added to the channel's running sum at each conversion end; acc_r keeps it, except at sequence end, when acc_r clears
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            sum_v[c] = acc_r[c];
            if (conv_end && chan_r == 2'(c)) begin
                sum_v[c] = acc_r[c] + {{11{adc_sample[15]}}, adc_sample};
            end
            avg_v[c] = 16'(sum_v[c] >>> shift);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < 3; c++) begin
                acc_r[c] <= '0;
            end
            for (int c = 0; c < 4; c++) begin
                res_r[c] <= '0;
            end
        end else if (soft_rst || adc_wr) begin
            for (int c = 0; c < 3; c++) begin
                acc_r[c] <= '0;
            end
        end else if (conv_end) begin
            if (seq_end) begin
                for (int c = 0; c < 3; c++) begin
                    acc_r[c] <= '0;
                    if (en[c] && shift != '0) begin
                        res_r[c] <= avg_v[c];
                    end
                end
                res_r[3] <= calc_power;
            end else begin
                acc_r[chan_r] <= sum_v[chan_r];
            end
            if (shift == '0) begin
                res_r[chan_r] <= adc_sample;
            end
        end
    end

    // limit comparison on raw or averaged data
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            cen[c] = opt_r[1] ? (seq_end && en[c]) : (conv_end && chan_r == 2'(c));
            cv[c]  = opt_r[1] ? avg_v[c] : adc_sample;
        end
        upd    = {seq_end, cen[2], cen[1], cen[1], cen[0], cen[0]};
        hit[0] = $signed(cv[0]) < $signed(thr_r[0]);
        hit[1] = $signed(cv[0]) > $signed(thr_r[1]);
        hit[2] = cv[1] > thr_r[2];
        hit[3] = cv[1] < thr_r[3];
        hit[4] = $signed(cv[2]) > $signed(thr_r[4]);
        hit[5] = calc_power > thr_r[5];
    end

    // status flags: a new event wins over a clearing read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cond_r  <= '0;
            flags_r <= '0;
            done_r  <= 1'b0;
            ovf_r   <= 1'b0;
        end else if (soft_rst) begin
            cond_r  <= '0;
            flags_r <= '0;
            done_r  <= 1'b0;
            ovf_r   <= 1'b0;
        end else begin
            cond_r  <= (cond_r & ~upd) | (hit & upd);
            flags_r <= (flags_r & ~{6{diag_rd}}) | (hit & upd);
            done_r  <= seq_end | (done_r & ~diag_rd & ~(adc_wr & ~shut_sel));
            ovf_r   <= calc_overflow | (ovf_r & ~diag_rd);
        end
    end

    // overflow and trim health are kept out of the alert term
    assign live = (|cond_r) | (opt_r[2] & done_r);
    assign act  = opt_r[3] ? (hold_r | live) : live;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_r   <= 1'b0;
            alert_oe <= 1'b0;
        end else begin
            // the read must win here, or a still-set done flag re-arms the latch
            hold_r   <= ~soft_rst & ~diag_rd & (live | hold_r);
            alert_oe <= opt_r[0] ? ~act : act;
        end
    end

    // pin is only ever pulled low; the pull-up makes the high level
    assign alert_out = 1'b0;

    assign diag_w = {opt_r, 2'b00, ovf_r, 1'b0, flags_r, done_r, trim_ok};

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            OFF_CONFIG: rd_mux[CFG_DLY_LSB +: 8] = dly_r;
            OFF_ADC:    rd_mux[15:0] = adc_cfg_r;
            OFF_SHUNT:  rd_mux[15:0] = res_r[0];
            OFF_BUS:    rd_mux[15:0] = res_r[1];
            OFF_TEMP:   rd_mux[15:0] = res_r[2];
            OFF_POWER:  rd_mux[15:0] = res_r[3];
            OFF_DIAG:   rd_mux[15:0] = diag_w;
            default:    rd_mux = '0;
        endcase
        for (int i = 0; i < 6; i++) begin
            if (avs_address == thr_off(i)) begin
                rd_mux[15:0] = thr_r[i];
            end
        end
    end

    // sampled in the wait cycle so data stands at the completing edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rd_mux;
        end
    end

    // helper: cycles since the current conversion began
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_cyc_r <= '0;
        end else if (adc_start) begin
            conv_cyc_r <= 32'd1;
        end else begin
            conv_cyc_r <= conv_cyc_r + 32'd1;
        end
    end

    chk_start_enabled: assert property (@(posedge clk) disable iff (!resetn)
        adc_start |-> en[adc_chan])
        else $error("conversion started on a disabled channel");
    chk_single_store: assert property (@(posedge clk) disable iff (!resetn)
        conv_end && shift == '0 && chan_r == CH_SHUNT && !soft_rst && !adc_wr
        |=> res_r[0] == $past(adc_sample))
        else $error("shunt result not stored at conversion end");
    chk_conv_len: assert property (@(posedge clk) disable iff (!resetn)
        conv_end |-> conv_cyc_r == 32'(ct_len(chan_r, adc_cfg_r)) * TICK_DIV - 32'd1)
        else $error("conversion length differs from selected time");
    chk_hold_result: assert property (@(posedge clk) disable iff (!resetn)
        !conv_end && !soft_rst |=> $stable(res_r[1]))
        else $error("bus result changed without a completed result");
    chk_trig_stop: assert property (@(posedge clk) disable iff (!resetn)
        seq_end && !mode[3] && !soft_rst && !adc_wr |=> state_r == PMA_IDLE ##1 !adc_start)
        else $error("triggered sequence did not stop");
    chk_mode_restart: assert property (@(posedge clk) disable iff (!resetn)
        adc_wr && !soft_rst && !shut_sel |=> state_r == PMA_WAIT && !adc_start)
        else $error("mode write did not restart the sequence");
    chk_done_set: assert property (@(posedge clk) disable iff (!resetn)
        seq_end && !soft_rst |=> done_r)
        else $error("done flag missing after sequence end");
    chk_done_clear: assert property (@(posedge clk) disable iff (!resetn)
        diag_rd && !seq_end |=> !done_r)
        else $error("done flag survived a diag read");
    chk_alert_latch: assert property (@(posedge clk) disable iff (!resetn)
        opt_r[3] && hold_r && !diag_rd && !wr_go |=> hold_r [*1] ##0 act)
        else $error("latched alert released without a diag read");
    chk_pin_polarity: assert property (@(posedge clk) disable iff (!resetn)
        !opt_r[0] && !act && !wr_go [*2] |-> !alert_oe)
        else $error("alert pin driven while inactive");
endmodule : pma_sequencer

// >>> pma_fe_model.sv
// Purpose: analog front end stand-in, a new sample for each conversion
// Assumes: one clock; the sequencer pulses adc_start
// Notes:   values stay small and positive, so no limit trips by accident
`timescale 1ns/100ps
module pma_fe_model (
    // clock
    input  wire logic        clk,
    // converter link
    input  wire logic        adc_start,
    output logic      [15:0] adc_sample
);
    initial adc_sample = 16'h0000;
    always @(posedge clk) begin
        if (adc_start) begin
            adc_sample <= {2'b00, 14'($urandom)} | 16'h0001;
        end
    end
endmodule : pma_fe_model

// >>> power_monitor_adc_sequencer_alert_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: TICK_DIV 4, so one microsecond is four clocks
// Notes:   the spacing of each conversion start, except the first after reset or after an ADC write, is checked as it happens
`timescale 1ns/100ps
module power_monitor_adc_sequencer_alert_tb;
    import pma_pkg::*;
    localparam int TD    = 4;
    localparam int CT[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    logic        clk = 0, resetn = 0, rd = 0, wr = 0, ovf = 0, pend = 0;
    logic        waitreq, adc_start, alert_out, alert_oe;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [1:0]  chan;
    logic [1:0]  prev = 2'h3;
    logic [15:0] sample;
    logic [15:0] adc_cfg = 16'hf000;
    logic [31:0] expq[$];
    int          mismatches = 0, comparisons = 0, cyc = 0, last = 0, starts = 0;
    int          acc[3], n[3];

    pma_sequencer #(.TICK_DIV(TD)) i_dut (.clk(clk), .resetn(resetn), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .adc_start(adc_start), .adc_chan(chan),
        .adc_sample(sample), .calc_power(16'h0010), .calc_overflow(ovf), .trim_ok(1'b1),
        .alert_out(alert_out), .alert_oe(alert_oe));
    pma_fe_model i_fe (.clk(clk), .adc_start(adc_start), .adc_sample(sample));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // a read queues d as its expected data; one idle edge keeps requests apart
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= w; rd <= !w;
        if (!w) expq.push_back(d);
        do @(posedge clk); while (waitreq);
        if (w && a == OFF_ADC) begin
            adc_cfg = d[15:0];
            prev = 2'h3;
        end
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus

    task automatic clear_acc;
        acc = '{0, 0, 0}; n = '{0, 0, 0}; starts = 0;
    endtask : clear_acc

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // read data taken at the completing edge
    always @(posedge clk) begin
        if (rd && !waitreq && expq.size() > 0) chk(rdata, expq.pop_front());
    end

    // conversion spacing and the first four samples per channel
    always @(negedge clk) begin
        if (pend && n[chan] < 4) begin
            acc[chan] += int'(sample);
            n[chan]++;
        end
        pend = adc_start;
        if (adc_start) begin
            starts++;
            if (prev != 2'h3) chk(32'(cyc - last),
                32'(CT[3'(adc_cfg >> (prev == 2'h0 ? 6 : prev == 2'h1 ? 9 : 3))] * TD));
            prev = chan;
            last = cyc;
        end
    end

    initial begin
        void'($urandom(71));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) bus(0, OFF_THR0 + 6'(4 * i), {16'h0, THR_RST[i]});
        bus(1, OFF_ADC, 32'h0);
        starts = 0;
        repeat (600) @(posedge clk);
        chk(starts, 0);
        bus(0, OFF_DIAG, 32'h0001);
        bus(1, OFF_THR0 + 6'h04, 32'h0);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        repeat (2) @(posedge clk);
        chk(alert_oe, 0);
        // triggered, shunt only, one sample
        clear_acc();
        bus(1, OFF_ADC, 32'h2000);
        repeat (400) @(posedge clk);
        chk(starts, 1);
        bus(0, OFF_SHUNT, {16'h0, 16'(acc[0])});
        chk(alert_oe, 1);
        bus(0, OFF_DIAG, 32'h020b);
        bus(1, OFF_DIAG, 32'h1000);
        repeat (2) @(posedge clk);
        chk(alert_oe, 0);
        bus(1, OFF_DIAG, 32'h0);
        bus(1, OFF_THR0 + 6'h04, 32'h7fff);
        // continuous, all channels, four samples averaged
        clear_acc();
        bus(1, OFF_ADC, 32'hf001);
        repeat (2430) @(posedge clk);
        chk(starts, 13);
        bus(0, OFF_SHUNT, {16'h0, 16'(acc[0] >>> 2)});
        bus(0, OFF_BUS, {16'h0, 16'(acc[1] >> 2)});
        bus(0, OFF_TEMP, {16'h0, 16'(acc[2] >>> 2)});
        // start delay of one step, then a single shot
        bus(1, OFF_ADC, 32'h0);
        bus(1, OFF_CONFIG, 32'h0100);
        clear_acc();
        bus(1, OFF_ADC, 32'h2000);
        repeat (7900) @(posedge clk);
        chk(starts, 0);
        repeat (500) @(posedge clk);
        chk(starts, 1);
        bus(0, OFF_DIAG, 32'h0003);
        bus(0, OFF_DIAG, 32'h0001);
        // latched alert with done on pin and averaged compare, no delay
        bus(1, OFF_CONFIG, 32'h0);
        bus(1, OFF_DIAG, 32'he000);
        bus(1, OFF_ADC, 32'h2000);
        repeat (300) @(posedge clk);
        chk(alert_oe, 1);
        bus(0, OFF_DIAG, 32'he003);
        repeat (2) @(posedge clk);
        chk(alert_oe, 0);
        print_verdict();
    end
endmodule : power_monitor_adc_sequencer_alert_tb
